// ---- brf_pkg.sv ----
// Constants shared by the branch and flags control block.
// Assumes a 32-bit APB slave on pclk with byte offsets in paddr[7:0].
package brf_pkg;

    // Register byte offsets on the APB side.
    localparam logic [7:0] OFS_OP = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_SP = 8'h0C;
    localparam logic [7:0] OFS_GREG = 8'h10;
    localparam logic [7:0] OFS_P4DIR = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_SYSCTL = 8'h1C;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
    localparam logic [7:0] OFS_MEM_DATA = 8'h24;

    // Operation word fields.
    localparam int OP_CODE_LSB = 0;
    localparam int OP_BITNO_LSB = 5;
    localparam int OP_COND_LSB = 8;
    localparam int OP_ARG_LSB = 16;

    // Operation codes carried in the low five bits of the operation word.
    localparam logic [4:0] OPC_IDLE = 5'h00;
    localparam logic [4:0] OPC_BRANCH = 5'h01;
    localparam logic [4:0] OPC_JUMP = 5'h02;
    localparam logic [4:0] OPC_CALL_ABS = 5'h03;
    localparam logic [4:0] OPC_CALL_REL = 5'h04;
    localparam logic [4:0] OPC_RETURN = 5'h05;
    localparam logic [4:0] OPC_EXC_RETURN = 5'h06;
    localparam logic [4:0] OPC_SLEEP = 5'h07;
    localparam logic [4:0] OPC_LOAD_IMM = 5'h08;
    localparam logic [4:0] OPC_LOAD_REG = 5'h09;
    localparam logic [4:0] OPC_STORE = 5'h0A;
    localparam logic [4:0] OPC_AND = 5'h0B;
    localparam logic [4:0] OPC_OR = 5'h0C;
    localparam logic [4:0] OPC_XOR = 5'h0D;
    localparam logic [4:0] OPC_BIT_SET = 5'h0E;
    localparam logic [4:0] OPC_BIT_CLEAR = 5'h0F;
    localparam logic [4:0] OPC_IRQ_ENTRY = 5'h10;

    // Flag positions inside the condition code register.
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;

    // Program counter steps and data space constants.
    localparam logic [15:0] PC_STEP_SHORT = 16'h0002;
    localparam logic [15:0] PC_STEP_LONG = 16'h0004;
    localparam logic [15:0] P4DIR_DATA_ADDR = 16'hFFB5;
    localparam logic [7:0] WRITE_ONLY_READ = 8'hFF;

    // Values after reset.
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam logic [7:0] P4DIR_RESET = 8'h00;

    // Operating states of the sequencer.
    typedef enum logic [2:0] {
        ST_READY, ST_BIT_RD, ST_BIT_WR, ST_PUSH, ST_POP, ST_SLEEP, ST_STANDBY
    } brf_state_type;

endpackage : brf_pkg

// ---- brf_cond_eval.sv ----
// Branch condition evaluator for the four-bit condition field.
// Assumes flags come straight from the condition code register.
module brf_cond_eval
    import brf_pkg::*;
(
    input wire logic [3:0] branch_condition_field,
    input wire logic [7:0] flags,
    output logic taken
);

    logic base;

    // Even codes test a flag term for zero; odd codes invert it.
    always_comb begin
        unique case (branch_condition_field[3:1])
            3'h0: base = 1'b1;
            3'h1: base = ~(flags[FLAG_C] | flags[FLAG_Z]);
            3'h2: base = ~flags[FLAG_C];
            3'h3: base = ~flags[FLAG_Z];
            3'h4: base = ~flags[FLAG_V];
            3'h5: base = ~flags[FLAG_N];
            3'h6: base = ~(flags[FLAG_N] ^ flags[FLAG_V]);
            3'h7: base = ~(flags[FLAG_Z] | (flags[FLAG_N] ^ flags[FLAG_V]));
        endcase
        taken = base ^ branch_condition_field[0];
    end

endmodule : brf_cond_eval

// ---- brf_core.sv ----
// Branch, call, return, sleep and flag operations behind an APB slave.
// Assumes an APB master on pclk; operations are issued by writing the
// operation word; a small byte memory holds the stack and bit targets.
// Operation
// - Bit set/clear reads, modifies, writes whole byte.
// - Port direction register reads back all ones.
// - Direction bit one means pin is output.
// - Evaluate condition field against flags.
// - Jump loads target without testing flags.
// - Absolute call jumps, saving return point.
// - Relative call adds signed displacement, saves return.
// - Interrupt entry stacks counter and flags.
// - Exception return restores flags and counter.
// - Sleep enters the power-down state.
// - Standby bit selects standby over sleep.
// - Flags load from immediate or general register.
// - Flags store copies into general register.
// - Flags AND with immediate byte.
// - Flags OR with immediate byte.
// - Flags XOR with immediate byte.
// - Idle only advances counter by two.
//
// Added by the designer: the APB slave port and the placing of the registers.
module brf_core
    import brf_pkg::*;
#(
    parameter int MEM_AW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic wake_in,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] port4_dir_out,
    output logic sleep_out,
    output logic standby_out
);

    brf_state_type state_ff, nxt_state;
    logic [31:0] op_ff, nxt_op;
    logic [15:0] pc_ff, nxt_pc;
    logic [15:0] sp_ff, nxt_sp;
    logic [15:0] ret_ff, nxt_ret;
    logic [15:0] maddr_ff, nxt_maddr;
    logic [7:0] flags_ff, nxt_flags;
    logic [7:0] greg_ff, nxt_greg;
    logic [7:0] dir_ff, nxt_dir;
    logic [7:0] rmw_ff, nxt_rmw;
    logic [1:0] step_ff, nxt_step;
    logic [1:0] last_ff, nxt_last;
    logic stby_en_ff, nxt_stby_en;
    logic taken_ff, nxt_taken;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, pslverr_ff, nxt_pslverr;
    logic sleep_ff, standby_ff;
    logic [7:0] mem [0:(1<<MEM_AW)-1];
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic access, busy, take, wr, issue, mapped, cond_true;
    logic [4:0] opc;
    logic [15:0] arg;
    logic [15:0] disp;
    logic [7:0] bit_mask, modified, push_byte, pop_byte;

    // Decode of the APB access phase; writes wait while an operation runs.
    assign access = psel & penable & ~pready_ff;
    assign busy = (state_ff == ST_BIT_RD) | (state_ff == ST_BIT_WR)
                | (state_ff == ST_PUSH) | (state_ff == ST_POP);
    assign take = access & ~(pwrite & busy);
    assign wr = take & pwrite;
    assign issue = wr & (paddr == OFS_OP) & (state_ff == ST_READY);
    assign opc = pwdata[OP_CODE_LSB +: 5];
    assign arg = pwdata[OP_ARG_LSB +: 16];
    assign disp = {{8{arg[7]}}, arg[7:0]};
    assign bit_mask = 8'h01 << op_ff[OP_BITNO_LSB +: 3];
    assign pop_byte = mem[sp_ff[MEM_AW-1:0]];

    // Modified byte of a bit operation, built from the byte read first.
    assign modified = (op_ff[OP_CODE_LSB +: 5] == OPC_BIT_SET)
                    ? (rmw_ff | bit_mask) : (rmw_ff & ~bit_mask);

    // Stacked bytes: return address low, return address high, then flags.
    always_comb begin
        unique case (step_ff)
            2'h0: push_byte = ret_ff[7:0];
            2'h1: push_byte = ret_ff[15:8];
            default: push_byte = flags_ff;
        endcase
    end

    // Condition test for the branch carried by the incoming word.
    brf_cond_eval u_cond (
        .branch_condition_field(pwdata[OP_COND_LSB +: 4]),
        .flags(flags_ff),
        .taken(cond_true)
    );

    // Sequencer: issues operations and walks multi-cycle ones.
    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_pc = pc_ff;
        nxt_sp = sp_ff;
        nxt_ret = ret_ff;
        nxt_maddr = maddr_ff;
        nxt_flags = flags_ff;
        nxt_greg = greg_ff;
        nxt_dir = dir_ff;
        nxt_rmw = rmw_ff;
        nxt_step = step_ff;
        nxt_last = last_ff;
        nxt_stby_en = stby_en_ff;
        nxt_taken = taken_ff;
        mem_we = 1'b0;
        mem_wa = maddr_ff[MEM_AW-1:0];
        mem_wd = pwdata[7:0];
        if (wr && !issue) begin
            unique case (paddr)
                OFS_PC: nxt_pc = pwdata[15:0];
                OFS_FLAGS: nxt_flags = pwdata[7:0];
                OFS_SP: nxt_sp = pwdata[15:0];
                OFS_GREG: nxt_greg = pwdata[7:0];
                OFS_P4DIR: nxt_dir = pwdata[7:0];
                OFS_SYSCTL: nxt_stby_en = pwdata[0];
                OFS_MEM_ADDR: nxt_maddr = pwdata[15:0];
                OFS_MEM_DATA: mem_we = 1'b1;
                default: ;
            endcase
        end
        unique case (state_ff)
            ST_READY: begin
                if (issue) begin
                    nxt_op = pwdata;
                    nxt_pc = pc_ff + PC_STEP_SHORT;
                    unique case (opc)
                        OPC_BRANCH: begin
                            nxt_taken = cond_true;
                            if (cond_true) begin
                                nxt_pc = pc_ff + PC_STEP_SHORT + disp;
                            end
                            // A false branch keeps the step-by-two counter
                            // and leaves every flag alone.
                        end
                        OPC_JUMP: nxt_pc = arg;
                        OPC_CALL_ABS: begin
                            nxt_ret = pc_ff + PC_STEP_LONG;
                            nxt_pc = arg;
                            nxt_last = 2'h1;
                            nxt_step = 2'h0;
                            nxt_state = ST_PUSH;
                        end
                        OPC_CALL_REL: begin
                            nxt_ret = pc_ff + PC_STEP_SHORT;
                            nxt_pc = pc_ff + PC_STEP_SHORT + disp;
                            nxt_last = 2'h1;
                            nxt_step = 2'h0;
                            nxt_state = ST_PUSH;
                        end
                        OPC_IRQ_ENTRY: begin
                            nxt_ret = pc_ff;
                            nxt_pc = arg;
                            nxt_last = 2'h2;
                            nxt_step = 2'h0;
                            nxt_state = ST_PUSH;
                        end
                        OPC_RETURN: begin
                            nxt_step = 2'h1;
                            nxt_state = ST_POP;
                        end
                        OPC_EXC_RETURN: begin
                            nxt_step = 2'h2;
                            nxt_state = ST_POP;
                        end
                        OPC_SLEEP: begin
                            nxt_state = stby_en_ff ? ST_STANDBY : ST_SLEEP;
                        end
                        OPC_LOAD_IMM: nxt_flags = arg[7:0];
                        OPC_LOAD_REG: nxt_flags = greg_ff;
                        OPC_STORE: nxt_greg = flags_ff;
                        OPC_AND: nxt_flags = flags_ff & arg[7:0];
                        OPC_OR: nxt_flags = flags_ff | arg[7:0];
                        OPC_XOR: nxt_flags = flags_ff ^ arg[7:0];
                        OPC_BIT_SET, OPC_BIT_CLEAR: begin
                            nxt_maddr = arg;
                            nxt_state = ST_BIT_RD;
                        end
                        default: ; // Idle steps by two.
                    endcase
                end
            end
            ST_BIT_RD: begin
                // The write-only direction register reads as all ones.
                nxt_rmw = (maddr_ff == P4DIR_DATA_ADDR) ? WRITE_ONLY_READ
                        : mem[maddr_ff[MEM_AW-1:0]];
                nxt_state = ST_BIT_WR;
            end
            ST_BIT_WR: begin
                if (maddr_ff == P4DIR_DATA_ADDR) begin
                    nxt_dir = modified;
                end else begin
                    mem_we = 1'b1;
                    mem_wd = modified;
                end
                nxt_state = ST_READY;
            end
            ST_PUSH: begin
                mem_we = 1'b1;
                mem_wa = MEM_AW'(sp_ff - 16'h0001); // Byte below the top.
                mem_wd = push_byte;
                nxt_sp = sp_ff - 16'h0001;
                nxt_step = step_ff + 2'h1;
                if (step_ff == last_ff) begin
                    nxt_state = ST_READY;
                end
            end
            ST_POP: begin
                unique case (step_ff)
                    2'h2: nxt_flags = pop_byte;
                    2'h1: nxt_pc = {pop_byte, pc_ff[7:0]};
                    default: nxt_pc = {pc_ff[15:8], pop_byte};
                endcase
                nxt_sp = sp_ff + 16'h0001;
                nxt_step = step_ff - 2'h1;
                if (step_ff == 2'h0) begin
                    nxt_state = ST_READY;
                end
            end
            ST_SLEEP, ST_STANDBY: begin
                if (wake_in || (wr && paddr == OFS_STATUS && pwdata[0])) begin
                    nxt_state = ST_READY;
                end
            end
        endcase
    end

    // Read data and error answer for the access phase.
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            OFS_OP: nxt_prdata = op_ff;
            OFS_PC: nxt_prdata = {16'h0000, pc_ff};
            OFS_FLAGS: nxt_prdata = {24'h00_0000, flags_ff};
            OFS_SP: nxt_prdata = {16'h0000, sp_ff};
            OFS_GREG: nxt_prdata = {24'h00_0000, greg_ff};
            OFS_P4DIR: nxt_prdata = {24'h00_0000, WRITE_ONLY_READ};
            OFS_STATUS: nxt_prdata = {28'h000_0000, taken_ff, standby_ff,
                                      sleep_ff, busy};
            OFS_SYSCTL: nxt_prdata = {31'h0000_0000, stby_en_ff};
            OFS_MEM_ADDR: nxt_prdata = {16'h0000, maddr_ff};
            OFS_MEM_DATA: nxt_prdata = {24'h00_0000,
                                        mem[maddr_ff[MEM_AW-1:0]]};
            default: mapped = 1'b0;
        endcase
        nxt_pslverr = ~mapped;
    end

    // Bus answer: one wait state, longer while a write waits on busy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            pready_ff <= take;
            pslverr_ff <= take & nxt_pslverr;
            prdata_ff <= (take && !pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    // Program flow state: counter, stack pointer and sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_READY;
            pc_ff <= PC_RESET;
            sp_ff <= SP_RESET;
            ret_ff <= PC_RESET;
            op_ff <= 32'h0000_0000;
            step_ff <= 2'h0;
            last_ff <= 2'h0;
            taken_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
            ret_ff <= nxt_ret;
            op_ff <= nxt_op;
            step_ff <= nxt_step;
            last_ff <= nxt_last;
            taken_ff <= nxt_taken;
        end
    end

    // Flags, general register and bit operation scratch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FLAGS_RESET;
            greg_ff <= 8'h00;
            rmw_ff <= 8'h00;
            maddr_ff <= 16'h0000;
        end else if (ce) begin
            flags_ff <= nxt_flags;
            greg_ff <= nxt_greg;
            rmw_ff <= nxt_rmw;
            maddr_ff <= nxt_maddr;
        end
    end

    // Port direction, standby select and power-down indications.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= P4DIR_RESET;
            stby_en_ff <= 1'b0;
            sleep_ff <= 1'b0;
            standby_ff <= 1'b0;
        end else if (ce) begin
            dir_ff <= nxt_dir;
            stby_en_ff <= nxt_stby_en;
            sleep_ff <= (nxt_state == ST_SLEEP);
            standby_ff <= (nxt_state == ST_STANDBY);
        end
    end

    // Byte memory for the stack and bit targets; one write port.
    always_ff @(posedge pclk) begin
        if (ce && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port4_dir_out = dir_ff; // A one drives the pin as output.
    assign sleep_out = sleep_ff;
    assign standby_out = standby_ff;

endmodule : brf_core

// ---- brf_core_props.sv ----
// Concurrent checks on the ports of the branch and flags control block.
// Assumes a single pclk domain with presetn as its asynchronous reset.
module brf_core_props
    import brf_pkg::*;
(
    input logic pclk,
    input logic presetn,
    input logic ce,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic wake_in,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [7:0] port4_dir_out,
    input logic sleep_out,
    input logic standby_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic done;
    logic wr_op;
    logic stby_en_ff;
    logic [2:0] bit_ff;

    // Finished transfer, and finished write of an operation word.
    assign done = psel && penable && pready;
    assign wr_op = done && pwrite && paddr == OFS_OP;

    // Standby enable as software last wrote it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stby_en_ff <= 1'b0;
        end else if (done && pwrite && paddr == OFS_SYSCTL) begin
            stby_en_ff <= pwdata[0];
        end
    end

    // Bit number of the last operation word, kept for the later write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_ff <= 3'h0;
        end else if (wr_op) begin
            bit_ff <= pwdata[OP_BITNO_LSB +: 3];
        end
    end

    property p_dir_read;
        done && !pwrite && paddr == OFS_P4DIR |-> prdata == 32'h000000FF;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read not all ones");

    property p_dir_write;
        done && pwrite && paddr == OFS_P4DIR |-> port4_dir_out == pwdata[7:0];
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction differs from write");

    property p_bit_clr;
        wr_op && pwdata[4:0] == OPC_BIT_CLEAR
            && pwdata[31:16] == P4DIR_DATA_ADDR
            |=> ##[0:2] port4_dir_out == ~(8'h01 << bit_ff);
    endproperty
    a_bit_clr: assert property (p_bit_clr)
        else $error("direction bit clear wrong");

    property p_sleep_go;
        wr_op && pwdata[4:0] == OPC_SLEEP && !wake_in
            |-> ##[0:2] (sleep_out || standby_out);
    endproperty
    a_sleep_go: assert property (p_sleep_go)
        else $error("sleep did not power down");

    property p_stby_sel;
        $rose(standby_out) |-> stby_en_ff && !sleep_out;
    endproperty
    a_stby_sel: assert property (p_stby_sel)
        else $error("standby with enable clear");

    property p_sleep_sel;
        $rose(sleep_out) |-> !stby_en_ff && !standby_out;
    endproperty
    a_sleep_sel: assert property (p_sleep_sel)
        else $error("sleep with standby enabled");

    property p_wake;
        (sleep_out || standby_out) && wake_in
            |-> ##[1:3] !(sleep_out || standby_out);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake did not end power down");

    property p_rdy_bound;
        $rose(psel && penable) |-> ##[1:8] pready;
    endproperty
    a_rdy_bound: assert property (p_rdy_bound)
        else $error("late answer");

    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready longer than one cycle");

    property p_unmapped;
        done && paddr > OFS_MEM_DATA |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    // Main scenarios of the bench.
    c_sleep: cover property ($rose(sleep_out));
    c_stby: cover property ($rose(standby_out));
    c_err: cover property (done && pslverr);
    c_bit: cover property (wr_op && pwdata[4:0] == OPC_BIT_CLEAR);
endmodule : brf_core_props

// ---- brf_core_tb.sv ----
// Self-checking bench for the branch and flags control block.
// Assumes brf_pkg, brf_core and the checker are compiled before it.
`define CHK(nm, xv, gv) begin n_checks++; if ((gv) !== (xv)) begin \
    n_mismatch++; $display("wrong value %s exp %h got %h", nm, xv, gv); end end
module brf_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import brf_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, wake_in;
    logic [7:0] paddr, port4_dir_out, f, d, a, b, g;
    logic [31:0] pwdata, prdata, r;
    logic pready, pslverr, sleep_out, standby_out, e;
    logic [15:0] p, t, np;
    int n_mismatch, n_checks;

    brf_core DUT (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .wake_in, .prdata, .pready, .pslverr, .port4_dir_out, .sleep_out,
        .standby_out
    );

    // Clock of 100 MHz.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Expected branch outcome; t8[k] is the term that code 2k tests for 0.
    function automatic logic cond_ok(input logic [3:0] c,
                                     input logic [7:0] fl);
        logic nv;
        logic [7:0] t8;
        nv = fl[FLAG_N] ^ fl[FLAG_V];
        t8 = {fl[FLAG_Z] | nv, nv, fl[FLAG_N], fl[FLAG_V], fl[FLAG_Z],
              fl[FLAG_C], fl[FLAG_C] | fl[FLAG_Z], 1'b0};
        return !t8[c[3:1]] ^ c[0];
    endfunction : cond_ok

    function automatic logic [15:0] sx(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : sx

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // One APB transfer, held until pready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] ad,
                        input logic [31:0] wd, output logic [31:0] rv,
                        output logic er);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            conclude();
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        xfer(1'b1, ad, wd, r, e);
    endtask : wr

    task automatic ck(input logic [7:0] ad, input logic [31:0] xv,
                      input string nm);
        xfer(1'b0, ad, 32'h0, r, e);
        `CHK(nm, xv, r)
    endtask : ck

    // Issues an operation word and polls until the block is idle.
    task automatic op(input logic [4:0] c, input logic [2:0] bn,
                      input logic [3:0] cf, input logic [15:0] ar);
        int n;
        wr(OFS_OP, {ar, 4'h0, cf, bn, c});
        n = 0;
        do begin
            xfer(1'b0, OFS_STATUS, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 10);
        if (r[0] !== 1'b0) begin
            n_mismatch++;
            conclude();
        end
    endtask : op

    // Waits, bounded, for both power-down outputs to drop.
    task automatic wait_awake();
        int n;
        n = 0;
        while ((sleep_out | standby_out) !== 1'b0 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        `CHK("awake", 1'b0, sleep_out | standby_out)
    endtask : wait_awake

    // Reset, then each operation family in turn.
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_in = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(32'h18DF));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("dir reset", 8'h00, port4_dir_out)
        ck(OFS_P4DIR, 32'hFF, "dir read");
        for (int i = 0; i < 48; i++) begin
            f = 8'($urandom);
            p = 16'($urandom);
            d = 8'($urandom);
            if (i[3:0] == 4'h0) begin
                p = 16'hFFFF;
                d = i[4] ? 8'h80 : 8'h7F;
            end
            wr(OFS_FLAGS, {24'h0, f});
            wr(OFS_PC, {16'h0, p});
            op(OPC_BRANCH, 3'h0, i[3:0], {8'h0, d});
            np = p + PC_STEP_SHORT + (cond_ok(i[3:0], f) ? sx(d) : 16'h0);
            ck(OFS_PC, {16'h0, np}, "branch pc");
            ck(OFS_FLAGS, {24'h0, f}, "branch flags");
        end
        wr(OFS_FLAGS, 32'h0F);
        p = 16'($urandom);
        t = 16'($urandom);
        wr(OFS_PC, {16'h0, p});
        op(OPC_IDLE, 3'h7, 4'h1, t);
        ck(OFS_PC, {16'h0, p + PC_STEP_SHORT}, "idle pc");
        ck(OFS_FLAGS, 32'h0F, "idle flags");
        op(OPC_JUMP, 3'h0, 4'h1, t);
        ck(OFS_PC, {16'h0, t}, "jump pc");
        wr(OFS_SP, 32'h0);
        p = 16'($urandom);
        op(OPC_CALL_ABS, 3'h0, 4'h0, p);
        ck(OFS_PC, {16'h0, p}, "call pc");
        ck(OFS_SP, 32'hFFFE, "call sp");
        op(OPC_RETURN, 3'h0, 4'h0, 16'h0);
        np = t + PC_STEP_LONG;
        ck(OFS_PC, {16'h0, np}, "return pc");
        d = 8'($urandom);
        op(OPC_CALL_REL, 3'h0, 4'h0, {8'h0, d});
        ck(OFS_PC, {16'h0, np + PC_STEP_SHORT + sx(d)}, "rel pc");
        op(OPC_RETURN, 3'h0, 4'h0, 16'h0);
        t = np + PC_STEP_SHORT;
        ck(OFS_PC, {16'h0, t}, "rel return");
        f = 8'($urandom);
        p = 16'($urandom);
        wr(OFS_FLAGS, {24'h0, f});
        op(OPC_IRQ_ENTRY, 3'h0, 4'h0, p);
        ck(OFS_PC, {16'h0, p}, "irq pc");
        ck(OFS_SP, 32'hFFFD, "irq sp");
        op(OPC_AND, 3'h0, 4'h0, 16'h0);
        ck(OFS_FLAGS, 32'h0, "and zero");
        op(OPC_EXC_RETURN, 3'h0, 4'h0, 16'h0);
        ck(OFS_PC, {16'h0, t}, "exc pc");
        ck(OFS_FLAGS, {24'h0, f}, "exc flags");
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            g = 8'($urandom);
            op(OPC_LOAD_IMM, 3'h0, 4'h0, {8'h0, a});
            ck(OFS_FLAGS, {24'h0, a}, "load imm");
            op(OPC_OR, 3'h0, 4'h0, {8'h0, b});
            ck(OFS_FLAGS, {24'h0, a | b}, "or");
            op(OPC_XOR, 3'h0, 4'h0, {8'h0, b});
            ck(OFS_FLAGS, {24'h0, (a | b) ^ b}, "xor");
            op(OPC_AND, 3'h0, 4'h0, {8'h0, g});
            ck(OFS_FLAGS, {24'h0, ((a | b) ^ b) & g}, "and");
            wr(OFS_GREG, {24'h0, g});
            op(OPC_LOAD_REG, 3'h0, 4'h0, 16'h0);
            ck(OFS_FLAGS, {24'h0, g}, "load reg");
            wr(OFS_GREG, {24'h0, ~g});
            op(OPC_STORE, 3'h0, 4'h0, 16'h0);
            ck(OFS_GREG, {24'h0, g}, "store");
        end
        wr(OFS_P4DIR, 32'h3F);
        `CHK("dir out", 8'h3F, port4_dir_out)
        op(OPC_BIT_CLEAR, 3'h0, 4'h0, P4DIR_DATA_ADDR);
        `CHK("dir rmw", 8'hFE, port4_dir_out)
        a = 8'($urandom);
        b = 8'($urandom);
        wr(OFS_MEM_ADDR, 32'h5);
        wr(OFS_MEM_DATA, {24'h0, a});
        op(OPC_BIT_SET, b[2:0], 4'h0, 16'h0045);
        g = a | (8'h01 << b[2:0]);
        ck(OFS_MEM_DATA, {24'h0, g}, "bit set");
        op(OPC_BIT_CLEAR, b[5:3], 4'h0, 16'h0045);
        g = g & ~(8'h01 << b[5:3]);
        ck(OFS_MEM_DATA, {24'h0, g}, "bit clear");
        wr(OFS_SYSCTL, 32'h0);
        op(OPC_SLEEP, 3'h0, 4'h0, 16'h0);
        `CHK("sleep", 2'b10, {sleep_out, standby_out})
        wake_in <= 1'b1;
        wait_awake();
        wake_in <= 1'b0;
        wr(OFS_SYSCTL, 32'h1);
        op(OPC_SLEEP, 3'h0, 4'h0, 16'h0);
        `CHK("standby", 2'b01, {sleep_out, standby_out})
        wr(OFS_STATUS, 32'h1);
        wait_awake();
        xfer(1'b0, 8'h40, 32'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        conclude();
    end
endmodule : brf_core_tb

bind brf_core brf_core_props u_props (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .wake_in, .prdata, .pready, .pslverr, .port4_dir_out, .sleep_out,
    .standby_out
);
